// *** rtl/scc_convert_ctrl.sv ***
// six-channel simultaneous sampling convert control: hold inputs, timing, result readout
// Operation
// [RULE_01] six inputs form three pairs, each with its own active-low hold request.
// [RULE_02] host holds a pair's hold request low at least 20 ns to start.
// [RULE_03] falling hold request freezes both stages of its pair and starts conversion.
// [RULE_04] hold requests asserted together sample two, four or six channels at once.
// [RULE_05] sample is taken at the hold falling edge, aperture typically 5 ns.
// [RULE_06] host keeps released hold high 15 ns at 5 V or 30 ns at 3 V.
// [RULE_07] latching a result pulses conversion done low for half a converter clock.
// [RULE_08] at 5 MHz conversion takes 3.2 us and acquisition 0.8 us.
// [RULE_09] host reads a result by driving read strobe and chip select low.
// [RULE_10] reads of the previous result may overlap the next conversion.
// [RULE_11] half-word select low drives all sixteen result bits onto the bus.
// [RULE_12] half-word select high puts result bits 15 to 8 on lines 7 to 0.
// [RULE_13] half-word select is asynchronous; bus follows it while read stays low.
// [RULE_14] acquisition plus conversion take twenty converter clock periods.
// [RULE_15] reset clears results, aborts conversions and closes the sampling switches.
// [RULE_16] mode select picks a direct channel, a cycle, or hold-ordered FIFO readout.
// [RULE_17] after a result latches the pair returns to sampling for the next acquisition.
`timescale 1ns/10ps
module scc_convert_ctrl
  import scc_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic convClk,
  input wire logic pairAHoldReqN,
  input wire logic pairBHoldReqN,
  input wire logic pairCHoldReqN,
  input wire logic [5:0][15:0] chanData,
  input wire logic readN,
  input wire logic chipSelN,
  input wire logic byteSel,
  input wire logic modeSelect0,
  input wire logic modeSelect1,
  input wire logic modeSelect2,
  output logic [15:0] busLineOut,
  output logic busLineOe,
  output logic convDoneN,
  output logic [2:0] pairSampling
);

  typedef struct packed {
    logic [2:0] holdS1;
    logic [2:0] holdS2;
    logic [2:0] holdPrev;
    logic convS1;
    logic convS2;
    logic convPrev;
    logic rdS1;
    logic rdS2;
    logic csS1;
    logic csS2;
    logic byteS1;
    logic byteS2;
    logic [2:0] modeS1;
    logic [2:0] modeS2;
    logic [5:0][15:0] chanS1;
    logic [5:0][15:0] chanS2;
    logic readPrev;
    logic [2:0] cyclePtr;
    logic [5:0][2:0] fifoIdx;
    logic [2:0] fifoCnt;
    logic [2:0] eocCnt;
    logic eocN;
    logic [15:0] busData;
    logic busOe;
  } scc_top_state_t;

  scc_top_state_t st;
  scc_top_state_t next_st;
  logic [2:0] holdFall;
  logic convTick;
  logic rdActive;
  logic readEnd;
  logic [2:0] selIdx;
  logic [15:0] selWord;
  logic [2:0] doneVec;
  logic [5:0][15:0] results;

  // ==========================================================================
  // edge detection on synchronised pins (second stage only)
  // [RULE_05] sample on hold fall
  assign holdFall = st.holdPrev & ~st.holdS2;
  assign convTick = st.convS2 & ~st.convPrev;
  // [RULE_09] read needs both strobes
  assign rdActive = !st.rdS2 && !st.csS2;
  assign readEnd = st.readPrev && !rdActive;

  // [RULE_16] channel picked by mode
  assign selIdx = (st.modeS2 == MODE_CYCLE) ? st.cyclePtr : (st.modeS2 == MODE_FIFO) ? st.fifoIdx[0] : st.modeS2;
  assign selWord = (st.modeS2 == MODE_FIFO && st.fifoCnt == 3'h0) ? RESULT_RST
                   : (selIdx > LAST_CHAN) ? RESULT_RST : results[selIdx];

  // ==========================================================================
  // three pair sequencers, one shared converter clock tick
  scc_pair_if pairLink[NUM_PAIRS] ();

  for (genvar g = 0; g < NUM_PAIRS; g++) begin : gPair
    // [RULE_01] one hold line per pair
    // [RULE_04] common tick and hold path
    assign pairLink[g].holdFall = holdFall[g];
    assign pairLink[g].convTick = convTick;
    assign pairLink[g].sampleIn = st.chanS2[2*g+1 -: 2];
    assign results[2*g+1 -: 2] = pairLink[g].result;
    assign doneVec[g] = pairLink[g].done;
    assign pairSampling[g] = pairLink[g].sampling;

    scc_pair_conv uConv (
      .mclk(mclk),
      .nrst(nrst),
      .link(pairLink[g])
    );
  end

  // ==========================================================================
  // synchronisers, readout pointers, fifo of channel order and end-of-conversion
  always_comb begin
    next_st = st;
    next_st.holdS1 = {pairCHoldReqN, pairBHoldReqN, pairAHoldReqN};
    next_st.holdS2 = st.holdS1;
    next_st.holdPrev = st.holdS2;
    next_st.convS1 = convClk;
    next_st.convS2 = st.convS1;
    next_st.convPrev = st.convS2;
    next_st.rdS1 = readN;
    next_st.rdS2 = st.rdS1;
    next_st.csS1 = chipSelN;
    next_st.csS2 = st.csS1;
    next_st.byteS1 = byteSel;
    next_st.byteS2 = st.byteS1;
    next_st.modeS1 = {modeSelect2, modeSelect1, modeSelect0};
    next_st.modeS2 = st.modeS1;
    next_st.chanS1 = chanData;
    next_st.chanS2 = st.chanS1;
    next_st.readPrev = rdActive;

    // [RULE_16] cycle and fifo advance when a read ends
    if (readEnd && st.modeS2 == MODE_CYCLE) begin
      next_st.cyclePtr = (st.cyclePtr == LAST_CHAN) ? 3'h0 : st.cyclePtr + 3'h1;
    end
    if (readEnd && st.modeS2 == MODE_FIFO && st.fifoCnt != 3'h0) begin
      next_st.fifoIdx = st.fifoIdx >> 3;
      next_st.fifoCnt = st.fifoCnt - 3'h1;
    end
    // pairs push in A, B, C order; a full queue drops the newer entries
    for (int p = 0; p < NUM_PAIRS; p++) begin
      for (int k = 0; k < 2; k++) begin
        if (doneVec[p] && next_st.fifoCnt < FIFO_DEPTH) begin
          next_st.fifoIdx[next_st.fifoCnt] = 3'(2 * p + k);
          next_st.fifoCnt = next_st.fifoCnt + 3'h1;
        end
      end
    end

    // [RULE_07] done pulse width
    // a later pair restarts the count: one merged pulse rather than two that could touch
    if (|doneVec) begin
      next_st.eocCnt = 3'(EOC_CYCLES);
    end else if (st.eocCnt != 3'h0) begin
      next_st.eocCnt = st.eocCnt - 3'h1;
    end
    next_st.eocN = (next_st.eocCnt == 3'h0);

    // [RULE_10] reads never wait on conversions
    // [RULE_11] full word or upper byte, refreshed every cycle of a read
    // [RULE_13] lane follows select mid-read
    // [RULE_12] upper byte to low lines
    next_st.busOe = rdActive;
    next_st.busData = rdActive ? scc_lane(selWord, st.byteS2) : st.busData;
  end

  // [RULE_15] reset clears outputs and queue
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st <= '{holdS1: 3'h7, holdS2: 3'h7, holdPrev: 3'h7, convS1: 1'b0, convS2: 1'b0, convPrev: 1'b0,
              rdS1: 1'b1, rdS2: 1'b1, csS1: 1'b1, csS2: 1'b1, byteS1: 1'b0, byteS2: 1'b0,
              modeS1: 3'h0, modeS2: 3'h0, chanS1: '0, chanS2: '0, readPrev: 1'b0, cyclePtr: 3'h0,
              fifoIdx: '0, fifoCnt: 3'h0, eocCnt: 3'h0, eocN: 1'b1, busData: RESULT_RST, busOe: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flip-flops; data keeps the last word once the read ends
  assign busLineOut = st.busData;
  assign busLineOe = st.busOe;
  assign convDoneN = st.eocN;

  // ==========================================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_eoc_width: assert property ($fell(convDoneN) |-> (!convDoneN)[*5]) // [RULE_07]
    else $error("done pulse shorter than half a converter clock");
  a_eoc_cause: assert property ($fell(convDoneN) |-> $past(|doneVec)) // [RULE_07]
    else $error("done pulse without a latched result");
  a_read_drive: assert property (rdActive |=> busLineOe) // [RULE_09]
    else $error("bus not driven during read");
  a_read_overlap: assert property (rdActive && pairSampling != 3'h7 // [RULE_10]
    |=> busLineOe && busLineOut == $past(scc_lane(selWord, st.byteS2)))
    else $error("read blocked by conversion");
  a_word_lane: assert property (rdActive && !st.byteS2 |=> busLineOut == $past(selWord)) // [RULE_11]
    else $error("full word not on bus");
  a_byte_lane: assert property (rdActive && st.byteS2 // [RULE_12]
    |=> busLineOut[15:8] == 8'h00 && busLineOut[7:0] == $past(selWord[15:8]))
    else $error("upper byte not on low lines");
  a_byte_follow: assert property (rdActive && $past(rdActive) && $changed(st.byteS2) // [RULE_13]
    |=> busLineOut == $past(scc_lane(selWord, st.byteS2)))
    else $error("bus missed half-word change");
  a_all_hold: assert property (holdFall == 3'h7 && pairSampling == 3'h7 |=> pairSampling == 3'h0) // [RULE_04]
    else $error("pairs did not hold together");
  a_cycle_step: assert property (readEnd && st.modeS2 == MODE_CYCLE // [RULE_16]
    |=> st.cyclePtr == (($past(st.cyclePtr) == LAST_CHAN) ? 3'h0 : $past(st.cyclePtr) + 3'h1))
    else $error("cycle pointer did not step");
  a_reset_clear: assert property (@(posedge mclk) disable iff (1'b0) !nrst // [RULE_15]
    |=> !busLineOe && convDoneN && pairSampling == 3'h7 && busLineOut == RESULT_RST)
    else $error("reset left state behind");

  c_all_pairs: cover property (holdFall == 3'h7 && pairSampling == 3'h7);
  c_fifo_read: cover property (readEnd && st.modeS2 == MODE_FIFO && st.fifoCnt != 3'h0);
  c_byte_switch: cover property (rdActive && $changed(st.byteS2));
  c_overlap: cover property (rdActive && pairSampling != 3'h7);

endmodule // scc_convert_ctrl

// *** rtl/scc_pkg.sv ***
// shared constants, types and helpers of the six-channel sample convert control
package scc_pkg;

  // ==========================================================================
  // clocks and times
  localparam int MCLK_PERIOD_NS = 20;
  localparam int CONV_CLK_PERIOD_NS = 200;
  localparam int ACQ_TIME_NS = 800;
  localparam int CONV_TIME_NS = 3200;
  localparam int HOLD_LOW_MIN_NS = 20;
  localparam int HOLD_HIGH_MIN_5V_NS = 15;
  localparam int HOLD_HIGH_MIN_3V_NS = 30;
  // acquisition and conversion counted in converter clock periods
  localparam int ACQ_TICKS = ACQ_TIME_NS / CONV_CLK_PERIOD_NS;
  localparam int CONV_TICKS = CONV_TIME_NS / CONV_CLK_PERIOD_NS;
  localparam int CYCLE_TICKS = ACQ_TICKS + CONV_TICKS;
  // end-of-conversion low for half a converter clock, rounded down, at least one cycle
  localparam int EOC_LOW_NS = CONV_CLK_PERIOD_NS / 2;
  localparam int EOC_CYCLES = (EOC_LOW_NS / MCLK_PERIOD_NS) < 1 ? 1 : (EOC_LOW_NS / MCLK_PERIOD_NS);

  // ==========================================================================
  // widths, codes, reset values
  localparam int NUM_PAIRS = 3;
  localparam int NUM_CHANS = 6;
  localparam int RES_W = 16;
  localparam int LANE_LO = 8;
  localparam logic [2:0] MODE_CYCLE = 3'h6;
  localparam logic [2:0] MODE_FIFO = 3'h7;
  localparam logic [2:0] LAST_CHAN = 3'h5;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [2:0] FIFO_DEPTH = 3'h6;

  typedef enum logic [2:0] {
    PH_SAMPLE = 3'b001,
    PH_CONVERT = 3'b010,
    PH_ACQUIRE = 3'b100
  } scc_phase_t;

  // ==========================================================================
  // helpers
  function automatic logic scc_last_tick(input logic [4:0] cnt, input int n);
    return cnt == 5'(n - 1);
  endfunction

  // half-word select: upper byte moves down to the low bus lines
  function automatic logic [15:0] scc_lane(input logic [15:0] w, input logic upper);
    return upper ? {8'h00, w[RES_W-1:LANE_LO]} : w;
  endfunction

endpackage

// *** rtl/scc_pair_if.sv ***
// link between the read/timing control and one channel pair converter
`timescale 1ns/10ps
interface scc_pair_if;
  logic holdFall;
  logic convTick;
  logic [1:0][15:0] sampleIn;
  logic [1:0][15:0] result;
  logic done;
  logic sampling;
  modport ctrl (output holdFall, output convTick, output sampleIn, input result, input done, input sampling);
  modport conv (input holdFall, input convTick, input sampleIn, output result, output done, output sampling);
endinterface

// *** rtl/scc_pair_conv.sv ***
// hold, conversion and acquisition sequencer of one channel pair
`timescale 1ns/10ps
module scc_pair_conv
  import scc_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  scc_pair_if.conv link
);

  typedef struct packed {
    scc_phase_t phase;
    logic [4:0] tickCnt;
    logic [1:0][15:0] held;
    logic [1:0][15:0] result;
    logic done;
  } scc_pair_state_t;

  scc_pair_state_t st;
  scc_pair_state_t next_st;

  // ==========================================================================
  // sequencer
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    case (st.phase)
      // [RULE_03] hold both stages
      PH_SAMPLE, PH_ACQUIRE: begin
        if (link.holdFall) begin
          next_st.held = link.sampleIn;
          next_st.tickCnt = 5'h00;
          next_st.phase = PH_CONVERT;
        end else if (st.phase == PH_ACQUIRE && link.convTick) begin
          // [RULE_14] acquisition closes cycle
          if (scc_last_tick(st.tickCnt, ACQ_TICKS)) begin
            next_st.phase = PH_SAMPLE;
          end else begin
            next_st.tickCnt = st.tickCnt + 5'h01;
          end
        end
      end
      // [RULE_08] sixteen-period conversion
      PH_CONVERT: begin
        if (link.convTick) begin
          if (scc_last_tick(st.tickCnt, CONV_TICKS)) begin
            next_st.result = st.held;
            next_st.done = 1'b1;
            // [RULE_17] back to sampling
            next_st.phase = PH_ACQUIRE;
            next_st.tickCnt = 5'h00;
          end else begin
            next_st.tickCnt = st.tickCnt + 5'h01;
          end
        end
      end
      default: next_st.phase = PH_SAMPLE;
    endcase
  end

  // [RULE_15] reset aborts and samples
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st <= '{phase: PH_SAMPLE, tickCnt: 5'h00, held: {RESULT_RST, RESULT_RST},
              result: {RESULT_RST, RESULT_RST}, done: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // switch is closed whenever the pair is not converting
  assign link.sampling = (st.phase != PH_CONVERT);
  assign link.result = st.result;
  assign link.done = st.done;

  // ==========================================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_hold_capture: assert property (link.holdFall && link.sampling // [RULE_03]
    |=> st.phase == PH_CONVERT && st.held == $past(link.sampleIn))
    else $error("hold did not freeze the pair");
  a_conv_length: assert property (link.done // [RULE_08]
    |-> $past(st.phase) == PH_CONVERT && $past(st.tickCnt) == 5'(CONV_TICKS - 1) && $past(link.convTick))
    else $error("conversion length wrong");
  a_return_sample: assert property (link.done |-> link.sampling && st.result == $past(st.held)) // [RULE_17]
    else $error("pair not sampling after result latch");
  a_acq_close: assert property (st.phase == PH_ACQUIRE && link.convTick // [RULE_14]
    && st.tickCnt == 5'(ACQ_TICKS - 1) && !link.holdFall |=> st.phase == PH_SAMPLE)
    else $error("acquisition length wrong");

endmodule // scc_pair_conv

// *** dv/scc_host_model.sv ***
// host model on the far side: pair hold requests and parallel-bus reads
`timescale 1ns/10ps
module scc_host_model (
  input wire logic mclk,
  input wire logic [15:0] busLineOut,
  input wire logic busLineOe,
  output logic [2:0] holdN,
  output logic readN,
  output logic chipSelN,
  output logic byteSel,
  output logic [2:0] modeSel
);
  // ==========================================================
  // idle levels: no hold requested, strobes released
  initial begin
    holdN = 3'h7;
    readN = 1'b1;
    chipSelN = 1'b1;
    byteSel = 1'b0;
    modeSel = 3'h0;
  end

  // ==========================================================
  // hold request, mask bit 0 is pair A
  // low for 60 ns
  task automatic hold(input logic [2:0] mask);
    @(posedge mclk);
    #1;
    holdN = ~mask;
    repeat (3) @(posedge mclk);
    #1;
    holdN = 3'h7;
    repeat (3) @(posedge mclk);
  endtask

  // ==========================================================
  // bus read; waits are bounded so a dead bus cannot hang us
  // select and strobe low
  task automatic rdOpen(input logic [2:0] mode, input logic bs);
    int n;
    @(posedge mclk);
    #1;
    modeSel = mode;
    byteSel = bs;
    chipSelN = 1'b0;
    readN = 1'b0;
    n = 0;
    while (busLineOe !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask

  // release, then wait for the bus to be let go
  task automatic rdClose();
    int n;
    @(posedge mclk);
    #1;
    readN = 1'b1;
    chipSelN = 1'b1;
    n = 0;
    while (busLineOe !== 1'b0 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask

  // whole read; an undriven bus returns unknown so it never matches
  task automatic read(input logic [2:0] mode, input logic bs, output logic [15:0] data);
    rdOpen(mode, bs);
    repeat (2) @(posedge mclk);
    #1;
    data = (busLineOe === 1'b1) ? busLineOut : 16'hXXXX;
    rdClose();
  endtask
endmodule // scc_host_model

// *** dv/testbench.sv ***
// self-checking bench of the six-channel sample convert control
`timescale 1ns/10ps
`define CHK(a, b) \
  begin \
    cmpCount++; \
    if ((a) !== (b)) begin \
      miscompares++; \
      $display("[ERR] %0t ns mismatch %h vs %h", $time, (a), (b)); \
    end \
  end
module testbench
  import scc_pkg::*;
;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic convClk = 1'b0;
  logic [5:0][15:0] chanData = '0;
  logic [2:0] holdN;
  logic [2:0] modeSel;
  logic readN;
  logic chipSelN;
  logic byteSel;
  logic [15:0] busLineOut;
  logic busLineOe;
  logic convDoneN;
  logic [2:0] pairSampling;
  int miscompares = 0;
  int cmpCount = 0;

  // ==========================================================
  // clocks: converter clock offset so its edges never meet mclk edges
  always #10 mclk = ~mclk;
  initial begin
    #7;
    forever #100 convClk = ~convClk;
  end

  scc_convert_ctrl i_dut (.mclk(mclk), .nrst(nrst), .convClk(convClk), .pairAHoldReqN(holdN[0]),
    .pairBHoldReqN(holdN[1]), .pairCHoldReqN(holdN[2]), .chanData(chanData), .readN(readN),
    .chipSelN(chipSelN), .byteSel(byteSel), .modeSelect0(modeSel[0]), .modeSelect1(modeSel[1]),
    .modeSelect2(modeSel[2]), .busLineOut(busLineOut), .busLineOe(busLineOe), .convDoneN(convDoneN),
    .pairSampling(pairSampling));
  scc_host_model i_host (.mclk(mclk), .busLineOut(busLineOut), .busLineOe(busLineOe), .holdN(holdN),
    .readN(readN), .chipSelN(chipSelN), .byteSel(byteSel), .modeSel(modeSel));

  // ==========================================================
  // helpers
  function automatic logic [15:0] pat(input int ch, input logic [15:0] base);
    return base + 16'(ch) * 16'h0101;
  endfunction

  task automatic setData(input logic [15:0] base);
    @(posedge mclk);
    #1;
    for (int c = 0; c < NUM_CHANS; c++) chanData[c] = pat(c, base);
  endtask

  task automatic rdChk(input logic [2:0] m, input logic bs, input logic [15:0] exp);
    logic [15:0] d;
    i_host.read(m, bs, d);
    `CHK(d, exp)
  endtask

  // one conversion: drop of sampling, conversion time, done pulse width
  task automatic convert(input logic [2:0] mask);
    int n;
    int w;
    int nom;
    nom = CONV_TICKS * CONV_CLK_PERIOD_NS / MCLK_PERIOD_NS;
    n = 0;
    w = 0;
    fork
      i_host.hold(mask);
    join_none
    while (pairSampling === 3'h7 && n < 10) begin
      @(posedge mclk);
      #1;
      n++;
    end
    `CHK(pairSampling, ~mask) // whole pairs at once
    n = 0;
    while (convDoneN !== 1'b0 && n < 400) begin
      @(posedge mclk);
      #1;
      n++;
    end
    `CHK(n >= nom - 12 && n <= nom + 12, 1'b1) // conversion time
    `CHK(pairSampling, 3'h7) // back to sampling
    while (convDoneN === 1'b0 && w < 20) begin
      @(posedge mclk);
      #1;
      w++;
    end
    `CHK(w, EOC_CYCLES) // done pulse width
    wait fork;
  endtask

  // ==========================================================
  // scenarios
  task automatic tReset();
    `CHK(busLineOe, 1'b0) // bus released
    `CHK(convDoneN, 1'b1) // no done
    `CHK(pairSampling, 3'h7) // switches closed
  endtask

  task automatic tPairA();
    setData(16'h1000);
    convert(3'h1);
    rdChk(3'h0, 1'b0, pat(0, 16'h1000)); // full word
    rdChk(3'h1, 1'b0, pat(1, 16'h1000)); // read strobes
    rdChk(3'h2, 1'b0, 16'h0000); // other pair untouched
  endtask

  task automatic tAllSix();
    setData(16'h2000);
    convert(3'h7);
    for (int c = 0; c < NUM_CHANS; c++) rdChk(3'(c), 1'b0, pat(c, 16'h2000)); // six channels
    rdChk(3'h3, 1'b1, pat(3, 16'h2000) >> 8); // upper byte low
  endtask

  task automatic tByteLive();
    i_host.rdOpen(3'h4, 1'b0);
    repeat (3) @(posedge mclk);
    #1;
    `CHK(busLineOut, pat(4, 16'h2000)) // full word
    i_host.byteSel = 1'b1;
    repeat (5) @(posedge mclk);
    #1;
    `CHK(busLineOut, pat(4, 16'h2000) >> 8) // follows select
    `CHK(busLineOe, 1'b1) // read still driven
    i_host.rdClose();
  endtask

  task automatic tOverlap();
    setData(16'h3000);
    fork
      convert(3'h2);
    join_none
    repeat (40) @(posedge mclk);
    rdChk(3'h2, 1'b0, pat(2, 16'h2000)); // old result mid conversion
    wait fork;
    rdChk(3'h2, 1'b0, pat(2, 16'h3000)); // new result after
  endtask

  // mid-run reset, then four channels read back in FIFO order and all six in cycle order
  task automatic tModes();
    logic [15:0] cyc [6];
    @(posedge mclk);
    #1;
    nrst = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    nrst = 1'b1;
    rdChk(3'h0, 1'b0, 16'h0000); // results cleared
    setData(16'h4000);
    convert(3'h5);
    cyc = '{pat(0, 16'h4000), pat(1, 16'h4000), 16'h0000, 16'h0000, pat(4, 16'h4000), pat(5, 16'h4000)};
    rdChk(3'h7, 1'b0, cyc[0]); // fifo order
    rdChk(3'h7, 1'b0, cyc[1]); // fifo order
    rdChk(3'h7, 1'b0, cyc[4]); // fifo order
    rdChk(3'h7, 1'b0, cyc[5]); // fifo order
    rdChk(3'h7, 1'b0, 16'h0000); // fifo empty
    for (int c = 0; c < NUM_CHANS; c++) rdChk(3'h6, 1'b0, cyc[c]); // cycle order
  endtask

  // ==========================================================
  // verdict and end of run
  task automatic testDone();
    if (miscompares == 0 && cmpCount > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // main sequence; reset held ten cycles
  initial begin
    repeat (10) @(posedge mclk);
    #1;
    nrst = 1'b1;
    tReset();
    tPairA();
    tAllSix();
    tByteLive();
    tOverlap();
    tModes();
    testDone();
  end

  // watchdog: the run needs well under 10000 cycles
  initial begin
    #300000;
    miscompares++;
    testDone();
  end
endmodule // testbench
